// *** rtl/pwmtpc_top.sv ***
// PWM trigger postscaler and output pin control with Wishbone registers
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module pwmtpc_top #(
  parameter bit IS_PRIMARY = 1'b1
) (
  input wire logic CLK_SYS, // 25 MHz system clock
  input wire logic RESET_N, // Async reset, active low
  input wire logic WB_CYC_I, // Wishbone cycle
  input wire logic WB_STB_I, // Wishbone strobe
  input wire logic WB_WE_I, // Wishbone write enable
  input wire logic [7:0] WB_ADR_I, // Wishbone byte address
  input wire logic [3:0] WB_SEL_I, // Wishbone byte selects
  input wire logic [31:0] WB_DAT_I, // Wishbone write data
  output logic [31:0] WB_DAT_O, // Wishbone read data
  output logic WB_ACK_O, // Wishbone acknowledge
  input wire logic CONFIG_WRITE_LOCK, // Device lock strap, async
  input wire logic PWM_CYCLE, // PWM period boundary pulse
  input wire logic TRIG_EVENT, // Trigger compare event pulse
  input wire logic GEN_HIGH, // Generator high-side signal
  input wire logic GEN_LOW, // Generator low-side signal
  input wire logic FAULT_ACTIVE, // Fault override level
  input wire logic CLIMIT_ACTIVE, // Current-limit override level
  output logic PIN_HIGH_O, // High pin output value
  output logic PIN_HIGH_OE, // High pin owned by PWM
  output logic PIN_LOW_O, // Low pin output value
  output logic PIN_LOW_OE, // Low pin owned by PWM
  output logic ADC_TRIGGER, // Postscaled ADC trigger pulse
  output logic TRIG_IRQ // Trigger interrupt request pulse
);
  logic [15:0] trg_ctrl_r;
  logic [15:0] pin_ctrl_r;
  logic [15:0] mod_ctrl_r;
  logic lock_meta_r;
  logic lock_sync_r;
  pwmtpc_pkg::pwmtpc_ul_t ul_state_r;
  logic [1:0] ovr_en_r;
  logic [1:0] ovr_dat_r;
  logic pp_phase_r;
  logic req;
  logic wr;
  logic wr_pin;
  logic pin_ok;
  logic trig_pulse;
  logic armed;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic hi_nxt;
  logic lo_nxt;
  pwmtpc_pkg::pwmtpc_mode_t mode;

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr = req & WB_WE_I;
  assign wdata = WB_DAT_I[15:0];
  assign pin_ok = ~lock_sync_r | (ul_state_r == pwmtpc_pkg::UL_OPEN);
  assign wr_pin = wr & (WB_ADR_I == pwmtpc_pkg::PIN_CTRL_OFS);
  assign mode = pwmtpc_pkg::pwmtpc_mode_t'(pin_ctrl_r[pwmtpc_pkg::MODE_LSB +: 2]);

  // Lock strap synchroniser
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      lock_meta_r <= 1'b0;
      lock_sync_r <= 1'b0;
    end else begin
      lock_meta_r <= CONFIG_WRITE_LOCK;
      lock_sync_r <= lock_meta_r;
    end
  end

  // Wishbone acknowledge, one cycle per request
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) WB_ACK_O <= 1'b0;
    else WB_ACK_O <= req;
  end

  // Read multiplexer
  always_comb begin
    case (WB_ADR_I)
      pwmtpc_pkg::TRG_CTRL_OFS: rdata = trg_ctrl_r & pwmtpc_pkg::TRG_CTRL_WMASK;
      pwmtpc_pkg::PIN_CTRL_OFS: rdata = pin_ctrl_r;
      pwmtpc_pkg::MOD_CTRL_OFS: rdata = mod_ctrl_r;
      pwmtpc_pkg::STATUS_OFS: rdata = {13'h0000, lock_sync_r,
                                       ul_state_r == pwmtpc_pkg::UL_OPEN, armed};
      default: rdata = 16'h0000;
    endcase
  end

  // Read data register
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) WB_DAT_O <= 32'h0000_0000;
    else if (req && !WB_WE_I) WB_DAT_O <= {16'h0000, rdata};
  end

  // Trigger and module control writes
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      trg_ctrl_r <= pwmtpc_pkg::TRG_CTRL_RST;
      mod_ctrl_r <= 16'h0000;
    end else if (wr) begin
      if (WB_ADR_I == pwmtpc_pkg::TRG_CTRL_OFS)
        trg_ctrl_r <= merge16(trg_ctrl_r, WB_DAT_I, WB_SEL_I) &
                      pwmtpc_pkg::TRG_CTRL_WMASK;
      if (WB_ADR_I == pwmtpc_pkg::MOD_CTRL_OFS)
        mod_ctrl_r <= merge16(mod_ctrl_r, WB_DAT_I, WB_SEL_I) & pwmtpc_pkg::MOD_CTRL_WMASK;
    end
  end

  // Pin control write, gated by the lock
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) pin_ctrl_r <= pwmtpc_pkg::PIN_CTRL_RST;
    else if (wr_pin && pin_ok) pin_ctrl_r <= merge16(pin_ctrl_r, WB_DAT_I, WB_SEL_I);
  end

  // Unlock sequence: two keys open one pin control write
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) ul_state_r <= pwmtpc_pkg::UL_IDLE;
    else if (wr_pin) ul_state_r <= pwmtpc_pkg::UL_IDLE;
    else if (wr && WB_ADR_I == pwmtpc_pkg::UNLOCK_OFS) begin
      case (ul_state_r)
        pwmtpc_pkg::UL_IDLE:
          ul_state_r <= (wdata == pwmtpc_pkg::UNLOCK_KEY1) ? pwmtpc_pkg::UL_KEY1
                                                            : pwmtpc_pkg::UL_IDLE;
        pwmtpc_pkg::UL_KEY1:
          ul_state_r <= (wdata == pwmtpc_pkg::UNLOCK_KEY2) ? pwmtpc_pkg::UL_OPEN
                                                            : pwmtpc_pkg::UL_IDLE;
        default: ul_state_r <= pwmtpc_pkg::UL_IDLE;
      endcase
    end
  end

  // Trigger delay and postscaler
  pwmtpc_trig_post #(
    .DIV_W(pwmtpc_pkg::DIV_W),
    .DLY_W(pwmtpc_pkg::DLY_W)
  ) u_post (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .enable(mod_ctrl_r[pwmtpc_pkg::ENABLE_BIT]),
    .pwm_cycle(PWM_CYCLE),
    .trig_event(TRIG_EVENT),
    .div(trg_ctrl_r[pwmtpc_pkg::TRG_DIV_LSB +: pwmtpc_pkg::DIV_W]),
    .delay(trg_ctrl_r[pwmtpc_pkg::TRG_DLY_LSB +: pwmtpc_pkg::DLY_W]),
    .trig_o(trig_pulse),
    .armed_o(armed)
  );

  // Trigger outputs
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ADC_TRIGGER <= 1'b0;
      TRIG_IRQ <= 1'b0;
    end else begin
      ADC_TRIGGER <= trig_pulse;
      TRIG_IRQ <= trig_pulse & IS_PRIMARY;
    end
  end

  // Active override settings, optionally held to the PWM boundary
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ovr_en_r <= 2'h0;
      ovr_dat_r <= 2'h0;
    end else if (!pin_ctrl_r[pwmtpc_pkg::OVERRIDE_SYNC_SEL_BIT] || PWM_CYCLE) begin
      ovr_en_r <= {pin_ctrl_r[pwmtpc_pkg::HI_OVR_EN_BIT], pin_ctrl_r[pwmtpc_pkg::LO_OVR_EN_BIT]};
      ovr_dat_r <= {pin_ctrl_r[pwmtpc_pkg::OVR_HI_BIT], pin_ctrl_r[pwmtpc_pkg::OVR_LO_BIT]};
    end
  end

  // Push-pull phase flips each PWM cycle
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) pp_phase_r <= 1'b0;
    else if (PWM_CYCLE) pp_phase_r <= ~pp_phase_r;
  end

  // Pin value path: mode, swap, override, limit, fault, polarity
  always_comb begin
    logic h;
    logic l;
    h = 1'b0;
    l = 1'b0;
    case (mode)
      pwmtpc_pkg::PAIR_COMPL: begin
        h = GEN_HIGH;
        l = ~GEN_HIGH;
      end
      pwmtpc_pkg::PAIR_REDUN: begin
        h = GEN_HIGH;
        l = GEN_HIGH;
      end
      pwmtpc_pkg::PAIR_PUSH: begin
        h = GEN_HIGH & ~pp_phase_r;
        l = GEN_HIGH & pp_phase_r;
      end
      default: begin
        h = 1'b0;
        l = 1'b0;
      end
    endcase
    hi_nxt = pin_ctrl_r[pwmtpc_pkg::SWAP_BIT] ? l : h;
    lo_nxt = pin_ctrl_r[pwmtpc_pkg::SWAP_BIT] ? h : l;
    if (ovr_en_r[1]) hi_nxt = ovr_dat_r[1];
    if (ovr_en_r[0]) lo_nxt = ovr_dat_r[0];
    if (CLIMIT_ACTIVE) begin
      hi_nxt = pin_ctrl_r[pwmtpc_pkg::CL_HI_BIT];
      lo_nxt = pin_ctrl_r[pwmtpc_pkg::CL_LO_BIT];
    end
    if (FAULT_ACTIVE) begin
      hi_nxt = pin_ctrl_r[pwmtpc_pkg::FLT_HI_BIT];
      lo_nxt = pin_ctrl_r[pwmtpc_pkg::FLT_LO_BIT];
    end
    hi_nxt = hi_nxt ^ pin_ctrl_r[pwmtpc_pkg::HI_POL_BIT];
    lo_nxt = lo_nxt ^ pin_ctrl_r[pwmtpc_pkg::LO_POL_BIT];
  end

  // Registered pin outputs
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      PIN_HIGH_O <= 1'b0;
      PIN_LOW_O <= 1'b0;
      PIN_HIGH_OE <= 1'b0;
      PIN_LOW_OE <= 1'b0;
    end else begin
      PIN_HIGH_O <= hi_nxt;
      PIN_LOW_O <= lo_nxt;
      PIN_HIGH_OE <= pin_ctrl_r[pwmtpc_pkg::HI_OWN_BIT];
      PIN_LOW_OE <= pin_ctrl_r[pwmtpc_pkg::LO_OWN_BIT];
    end
  end

  // Plain generator path with no override in play
  logic plain;
  assign plain = ~FAULT_ACTIVE & ~CLIMIT_ACTIVE & (ovr_en_r == 2'h0) &
                 (pin_ctrl_r[pwmtpc_pkg::LO_POL_BIT +: 2] == 2'h0) &
                 (mode == pwmtpc_pkg::PAIR_COMPL);

  sequence s_trig_seen;
    trig_pulse ##1 ADC_TRIGGER;
  endsequence
  sequence s_key_pair;
    wr && WB_ADR_I == pwmtpc_pkg::UNLOCK_OFS && wdata == pwmtpc_pkg::UNLOCK_KEY1
    ##1 !wr [*2] ##1 wr && WB_ADR_I == pwmtpc_pkg::UNLOCK_OFS &&
    wdata == pwmtpc_pkg::UNLOCK_KEY2;
  endsequence

  a_irq_primary: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    s_trig_seen |-> TRIG_IRQ == IS_PRIMARY) else $error("interrupt role wrong");
  a_trg_rsvd: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (trg_ctrl_r & ~pwmtpc_pkg::TRG_CTRL_WMASK) == 16'h0000)
    else $error("reserved trigger bits set");
  a_lock_block: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    wr_pin && lock_sync_r && ul_state_r != pwmtpc_pkg::UL_OPEN |=> $stable(pin_ctrl_r))
    else $error("locked pin control written");
  a_unlock_open: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    ul_state_r == pwmtpc_pkg::UL_IDLE ##0 s_key_pair |=> ul_state_r == pwmtpc_pkg::UL_OPEN)
    else $error("unlock sequence failed");
  a_swap_route: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    plain && pin_ctrl_r[pwmtpc_pkg::SWAP_BIT] |=> PIN_HIGH_O == !$past(GEN_HIGH) &&
    PIN_LOW_O == $past(GEN_HIGH)) else $error("swap routing wrong");
  a_compl_pair: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    RESET_N && plain && !pin_ctrl_r[pwmtpc_pkg::SWAP_BIT] |=> PIN_HIGH_O != PIN_LOW_O)
    else $error("complementary pair equal");
  a_rsvd_mode: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    mode == pwmtpc_pkg::PAIR_RSVD && !FAULT_ACTIVE && !CLIMIT_ACTIVE && ovr_en_r == 2'h0 &&
    pin_ctrl_r[pwmtpc_pkg::LO_POL_BIT +: 2] == 2'h0 |=> !PIN_HIGH_O && !PIN_LOW_O)
    else $error("reserved mode drove pins");
  a_ovr_data: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    ovr_en_r[1] && !FAULT_ACTIVE && !CLIMIT_ACTIVE |=>
    PIN_HIGH_O == ($past(ovr_dat_r[1]) ^ $past(pin_ctrl_r[pwmtpc_pkg::HI_POL_BIT])))
    else $error("override data not driven");
  a_ovr_sync: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    pin_ctrl_r[pwmtpc_pkg::OVERRIDE_SYNC_SEL_BIT] && !PWM_CYCLE |=> $stable(ovr_en_r))
    else $error("override changed off boundary");
endmodule

// *** pkg/pwmtpc_pkg.sv ***
// Constants and types for the PWM trigger and pin control block
package pwmtpc_pkg;
  localparam int ADR_W = 8;
  localparam int REG_W = 16;
  localparam int DIV_W = 4;
  localparam int DLY_W = 6;
  // Register byte offsets
  localparam logic [7:0] TRG_CTRL_OFS = 8'h00;
  localparam logic [7:0] PIN_CTRL_OFS = 8'h04;
  localparam logic [7:0] MOD_CTRL_OFS = 8'h08;
  localparam logic [7:0] UNLOCK_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  // Reset values and write masks
  localparam logic [15:0] TRG_CTRL_RST = 16'h0000;
  localparam logic [15:0] PIN_CTRL_RST = 16'hc000;
  localparam logic [15:0] TRG_CTRL_WMASK = 16'hf03f;
  localparam logic [15:0] MOD_CTRL_WMASK = 16'h0001;
  // Trigger control fields
  localparam int TRG_DIV_LSB = 12;
  localparam int TRG_DLY_LSB = 0;
  // Pin output control fields
  localparam int HI_OWN_BIT = 15;
  localparam int LO_OWN_BIT = 14;
  localparam int HI_POL_BIT = 13;
  localparam int LO_POL_BIT = 12;
  localparam int MODE_LSB = 10;
  localparam int HI_OVR_EN_BIT = 9;
  localparam int LO_OVR_EN_BIT = 8;
  localparam int OVR_HI_BIT = 7;
  localparam int OVR_LO_BIT = 6;
  localparam int FLT_HI_BIT = 5;
  localparam int FLT_LO_BIT = 4;
  localparam int CL_HI_BIT = 3;
  localparam int CL_LO_BIT = 2;
  localparam int SWAP_BIT = 1;
  localparam int OVERRIDE_SYNC_SEL_BIT = 0;
  // Module control fields
  localparam int ENABLE_BIT = 0;
  // Unlock keys, values arbitrary
  localparam logic [15:0] UNLOCK_KEY1 = 16'h00a5;
  localparam logic [15:0] UNLOCK_KEY2 = 16'h005a;
  // Pin-pair mode encodings
  typedef enum logic [1:0] {
    PAIR_COMPL = 2'h0,
    PAIR_REDUN = 2'h1,
    PAIR_PUSH = 2'h2,
    PAIR_RSVD = 2'h3
  } pwmtpc_mode_t;
  // Unlock sequence states
  typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_OPEN} pwmtpc_ul_t;
endpackage

// *** rtl/pwmtpc_trig_post.sv ***
// Trigger start delay and postscaler
`timescale 1ns/1ps
module pwmtpc_trig_post #(
  parameter int DIV_W = 4,
  parameter int DLY_W = 6
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic enable, // Module enable level
  input wire logic pwm_cycle, // PWM period boundary pulse
  input wire logic trig_event, // Trigger compare event pulse
  input wire logic [DIV_W-1:0] div, // Postscale value
  input wire logic [DLY_W-1:0] delay, // Start delay in PWM cycles
  output logic trig_o, // Postscaled trigger pulse
  output logic armed_o // Start delay has elapsed
);
  logic en_d_r;
  logic [DLY_W-1:0] dly_cnt_r;
  logic [DIV_W-1:0] post_cnt_r;
  logic start;
  logic hit;

  assign start = enable & ~en_d_r;
  assign hit = armed_o & trig_event & (post_cnt_r >= div);

  // Enable edge detect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) en_d_r <= 1'b0;
    else en_d_r <= enable;
  end

  // Start delay counting of PWM cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_cnt_r <= '0;
      armed_o <= 1'b0;
    end else if (!enable) begin
      armed_o <= 1'b0;
    end else if (start) begin
      dly_cnt_r <= delay;
      armed_o <= (delay == '0);
    end else if (!armed_o && pwm_cycle) begin
      dly_cnt_r <= dly_cnt_r - 1'b1;
      armed_o <= (dly_cnt_r == DLY_W'(1));
    end
  end

  // Event postscaler
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      post_cnt_r <= '0;
      trig_o <= 1'b0;
    end else begin
      trig_o <= hit;
      if (!armed_o) post_cnt_r <= '0;
      else if (trig_event) post_cnt_r <= hit ? '0 : post_cnt_r + 1'b1;
    end
  end

  a_post_pass: assert property (@(posedge clk) disable iff (!rst_n)
    hit |=> trig_o) else $error("postscaled trigger missing");
  a_post_hold: assert property (@(posedge clk) disable iff (!rst_n)
    armed_o && trig_event && post_cnt_r < div |=> !trig_o)
    else $error("trigger before count reached");
  a_dly_block: assert property (@(posedge clk) disable iff (!rst_n)
    !armed_o |=> !trig_o) else $error("trigger during start delay");
  a_dly_zero: assert property (@(posedge clk) disable iff (!rst_n)
    start && delay == '0 |=> armed_o) else $error("zero delay not armed at once");
endmodule

// *** verif/pwmtpc_stage_model.sv ***
// Power stage and ADC trigger input seen from the far side of the pins
`timescale 1ns/1ps
module pwmtpc_stage_model (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic pin_high_o, // High pin value
  input wire logic pin_high_oe, // High pin driven by PWM
  input wire logic pin_low_o, // Low pin value
  input wire logic pin_low_oe, // Low pin driven by PWM
  input wire logic adc_trigger, // Trigger pulse into the converter
  output logic high_lvl, // Level seen on the high pin
  output logic low_lvl, // Level seen on the low pin
  output int trig_cnt // Conversions started so far
);
  logic hi_last_r;
  logic lo_last_r;
  // Undriven pins float: show the inverse of the last driven level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_last_r <= 1'b0;
      lo_last_r <= 1'b0;
    end else begin
      if (pin_high_oe) hi_last_r <= pin_high_o;
      if (pin_low_oe) lo_last_r <= pin_low_o;
    end
  end
  assign high_lvl = pin_high_oe ? pin_high_o : ~hi_last_r;
  assign low_lvl = pin_low_oe ? pin_low_o : ~lo_last_r;
  // Each sampled trigger pulse starts one conversion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) trig_cnt <= 0;
    else if (adc_trigger === 1'b1) trig_cnt <= trig_cnt + 1;
  end
endmodule

// *** verif/pwmtpc_top_tb.sv ***
// Self-checking bench for the PWM trigger and pin control block
`timescale 1ns/1ps
module pwmtpc_top_tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic ack;
  logic lock = 1'b0;
  logic pwm_cyc = 1'b0;
  logic trg_ev = 1'b0;
  logic gen_h = 1'b0;
  logic gen_l = 1'b0;
  logic flt = 1'b0;
  logic clim = 1'b0;
  logic ph_o, ph_oe, pl_o, pl_oe, adc_trg, irq, sec_irq, hi_lvl, lo_lvl;
  int trig_cnt;
  int irq_cnt = 0;
  int sec_irq_cnt = 0;
  int error_cnt = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [20:0] pin_tab [14] = '{{16'hc000, 5'h12}, {16'hc000, 5'h01}, {16'hc400, 5'h13},
    {16'hcc00, 5'h10}, {16'hc002, 5'h11}, {16'he000, 5'h10}, {16'hc380, 5'h02},
    {16'hc340, 5'h11}, {16'hc020, 5'h0a}, {16'hc008, 5'h06}, {16'hc018, 5'h0d},
    {16'h4400, 5'h13}, {16'hd000, 5'h13}, {16'hc800, 5'h11}};

  always #20 clk_sys = ~clk_sys;

  pwmtpc_top i_dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .CONFIG_WRITE_LOCK(lock), .PWM_CYCLE(pwm_cyc), .TRIG_EVENT(trg_ev),
    .GEN_HIGH(gen_h), .GEN_LOW(gen_l), .FAULT_ACTIVE(flt), .CLIMIT_ACTIVE(clim),
    .PIN_HIGH_O(ph_o), .PIN_HIGH_OE(ph_oe), .PIN_LOW_O(pl_o), .PIN_LOW_OE(pl_oe),
    .ADC_TRIGGER(adc_trg), .TRIG_IRQ(irq));
  // Secondary generator fed the same stimulus; only its interrupt is watched
  pwmtpc_top #(.IS_PRIMARY(1'b0)) i_dut_sec (.CLK_SYS(clk_sys), .RESET_N(reset_n),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(), .WB_ACK_O(), .CONFIG_WRITE_LOCK(lock),
    .PWM_CYCLE(pwm_cyc), .TRIG_EVENT(trg_ev), .GEN_HIGH(gen_h), .GEN_LOW(gen_l),
    .FAULT_ACTIVE(flt), .CLIMIT_ACTIVE(clim), .PIN_HIGH_O(), .PIN_HIGH_OE(),
    .PIN_LOW_O(), .PIN_LOW_OE(), .ADC_TRIGGER(), .TRIG_IRQ(sec_irq));
  pwmtpc_stage_model i_stage (.clk(clk_sys), .rst_n(reset_n), .pin_high_o(ph_o),
    .pin_high_oe(ph_oe), .pin_low_o(pl_o), .pin_low_oe(pl_oe), .adc_trigger(adc_trg),
    .high_lvl(hi_lvl), .low_lvl(lo_lvl), .trig_cnt(trig_cnt));

  // Interrupt pulse counters and hang guard
  always @(posedge clk_sys) begin
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (sec_irq !== 1'b0 && reset_n) sec_irq_cnt <= sec_irq_cnt + 1;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      error_cnt = error_cnt + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    wdat <= {16'h0000, d};
    do @(posedge clk_sys); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic pulse(input bit ev, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      if (ev) trg_ev <= 1'b1;
      else pwm_cyc <= 1'b1;
      @(posedge clk_sys);
      trg_ev <= 1'b0;
      pwm_cyc <= 1'b0;
    end
  endtask

  task automatic settle();
    repeat (4) @(posedge clk_sys);
  endtask

  // Reset values, unused bits and an unmapped address
  task automatic t_regs();
    chk("pin owners", {ph_oe, pl_oe}, 2'h3);
    wb(0, pwmtpc_pkg::TRG_CTRL_OFS, 16'h0000);
    chk("trig ctrl reset", rd, {16'h0000, pwmtpc_pkg::TRG_CTRL_RST});
    wb(0, pwmtpc_pkg::PIN_CTRL_OFS, 16'h0000);
    chk("pin ctrl reset", rd, {16'h0000, pwmtpc_pkg::PIN_CTRL_RST});
    wb(1, pwmtpc_pkg::TRG_CTRL_OFS, 16'hffff);
    wb(0, pwmtpc_pkg::TRG_CTRL_OFS, 16'h0000);
    chk("trig ctrl unused", rd, 32'h0000f03f);
    wb(1, 8'h14, 16'hffff);
    wb(0, 8'h14, 16'h0000);
    chk("unmapped read", rd, 32'h00000000);
  endtask

  // Postscale n with start delay d; early events must be dropped
  task automatic t_trig(input logic [3:0] n, input logic [5:0] d);
    int base;
    int ibase;
    wb(1, pwmtpc_pkg::MOD_CTRL_OFS, 16'h0000);
    wb(1, pwmtpc_pkg::TRG_CTRL_OFS, {n, 6'h00, d});
    wb(1, pwmtpc_pkg::MOD_CTRL_OFS, 16'h0001);
    base = trig_cnt;
    ibase = irq_cnt;
    if (d != 0) begin
      pulse(0, d - 1);
      pulse(1, n + 1);
      settle();
      chk("trig before delay", trig_cnt - base, 0);
      pulse(0, 1);
    end
    settle();
    pulse(1, n);
    settle();
    chk("trig short count", trig_cnt - base, 0);
    pulse(1, 1);
    settle();
    chk("trig first", trig_cnt - base, 1);
    pulse(1, n + 1);
    settle();
    chk("trig second", trig_cnt - base, 2);
    chk("primary irq", irq_cnt - ibase, 2);
    chk("secondary irq", sec_irq_cnt, 0);
  endtask

  // Pin modes, swap, polarity, override and fault data from the table
  task automatic t_pins();
    logic [20:0] t;
    for (int i = 0; i < 14; i++) begin
      t = pin_tab[i];
      wb(1, pwmtpc_pkg::PIN_CTRL_OFS, t[20:5]);
      gen_h <= t[4];
      gen_l <= ~t[4];
      flt <= t[3];
      clim <= t[2];
      settle();
      chk("pin owners", {ph_oe, pl_oe}, t[20:19]);
      if (t[20]) chk("high pin", hi_lvl, t[1]);
      if (t[19]) chk("low pin", lo_lvl, t[0]);
    end
    flt <= 1'b0;
    clim <= 1'b0;
    // Push-pull: 65 boundaries so far put the low pin in turn; one more hands over
    pulse(0, 1);
    settle();
    chk("push phase", {hi_lvl, lo_lvl}, 2'h2);
  endtask

  // Synchronised override waits for the PWM boundary
  task automatic t_override_sync_sel();
    wb(1, pwmtpc_pkg::PIN_CTRL_OFS, 16'hc000);
    gen_h <= 1'b0;
    settle();
    wb(1, pwmtpc_pkg::PIN_CTRL_OFS, 16'hc381);
    settle();
    chk("sync hold", {hi_lvl, lo_lvl}, 2'h1);
    pulse(0, 1);
    settle();
    chk("sync apply", {hi_lvl, lo_lvl}, 2'h2);
  endtask

  // Locked pin control needs the key pair, and it opens one write
  task automatic t_lock();
    lock <= 1'b1;
    wb(1, pwmtpc_pkg::PIN_CTRL_OFS, 16'hc000);
    settle();
    wb(1, pwmtpc_pkg::PIN_CTRL_OFS, 16'hc400);
    wb(0, pwmtpc_pkg::PIN_CTRL_OFS, 16'h0000);
    chk("locked write", rd, 32'h0000c000);
    wb(1, pwmtpc_pkg::UNLOCK_OFS, pwmtpc_pkg::UNLOCK_KEY1);
    wb(1, pwmtpc_pkg::UNLOCK_OFS, pwmtpc_pkg::UNLOCK_KEY2);
    wb(0, pwmtpc_pkg::STATUS_OFS, 16'h0000);
    chk("status open", rd, 32'h00000007);
    wb(1, pwmtpc_pkg::PIN_CTRL_OFS, 16'hc400);
    wb(1, pwmtpc_pkg::PIN_CTRL_OFS, 16'hc800);
    wb(0, pwmtpc_pkg::PIN_CTRL_OFS, 16'h0000);
    chk("unlocked write", rd, 32'h0000c400);
    lock <= 1'b0;
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_regs();
    t_trig(4'h0, 6'h00);
    t_trig(4'h3, 6'h02);
    t_trig(4'hf, 6'h3f);
    t_pins();
    t_override_sync_sel();
    t_lock();
    report_and_stop();
  end
endmodule
